// *** e1rlo_pkg.sv ***
// Functional notes
// - One global mode bit: clear selects E1, set selects T1/J1; resets to one.
// - Eight per-framer receive line option registers, 80H apart from zero, reset zero.
// - Bypass bit clear routes data through jitter FIFO; set skips it, saving ~24 bits.
// - Freeze bit set stops the frame processor searching for alignment.
// - Freeze bit set holds signaling frozen; automatic frame-loss treats OOF as declared.
// - NFAS counting off: each FAS bit error counts, or one per pattern in word mode.
// - Word mode off, NFAS counting on: FAS bit errors plus NFAS second bit zero.
// - Both set: FAS plus next NFAS second bit form one 8-bit word, one error max.
// - Auto remote alarm off: RAI bit sent only when remote alarm force is set.
// - Auto remote alarm on: RAI sent while alignment lost, or while AIS received with condition select set.
// - A condition select bit adds received AIS to frame loss as a trigger for automatic RAI.
// - Auto trunk on red: replace receive data with trunk code while red alarm is one.
// - Auto trunk on frame loss: replace receive data while out-of-basic-frame is one.
// - Auto counter latch on: latch monitor and detector counters once every second.
// - Auto counter latch off: counters latch only on explicit host request.
package e1rlo_pkg;
    localparam int E1RLO_FRAMERS = 8;
    localparam logic [11:0] E1RLO_LINE_BASE = 12'h000;
    localparam logic [11:0] E1RLO_LINE_STRIDE = 12'h080;
    localparam logic [11:0] E1RLO_MODE_ADDR = 12'h400;
    localparam logic [11:0] E1RLO_CTRL_ADDR = 12'h404;
    localparam logic [11:0] E1RLO_IRQ_STAT_ADDR = 12'h408;
    localparam logic [11:0] E1RLO_IRQ_CLR_ADDR = 12'h40c;
    localparam logic [11:0] E1RLO_IRQ_EN_ADDR = 12'h410;
    localparam logic [11:0] E1RLO_FER_ADDR = 12'h418;
    localparam logic [7:0] E1RLO_LINE_RESET = 8'h00;
    localparam logic E1RLO_MODE_RESET = 1'b1;
    // Field positions of a line option register
    localparam int E1RLO_B_BYPASS = 7;
    localparam int E1RLO_B_FREEZE = 6;
    localparam int E1RLO_B_WORD = 5;
    localparam int E1RLO_B_NFAS = 4;
    localparam int E1RLO_B_AUTORAI = 3;
    localparam int E1RLO_B_AUTO_TRUNK_ON_RED = 2;
    localparam int E1RLO_B_AUTO_TRUNK_ON_FRAME_LOSS = 1;
    localparam int E1RLO_B_AUTOLATCH = 0;
    // Control register fields: remote alarm force, condition select, update request
    localparam int E1RLO_C_FORCE = 0;
    localparam int E1RLO_C_CSEL = 8;
    localparam int E1RLO_C_UPD = 16;
    localparam int E1RLO_SECOND_NS = 1000000000;
    localparam int E1RLO_CLK_NS = 8;
    localparam int E1RLO_SECOND_CYC = E1RLO_SECOND_NS / E1RLO_CLK_NS;
    localparam logic [6:0] E1RLO_FAS_WORD = 7'h1b;

    // Per-framer alarm and framing inputs from the receive datapath
    typedef struct packed {
        logic fas_valid;
        logic [6:0] fas_bits;
        logic nfas_valid;
        logic nfas_bit2;
        logic red_alarm;
        logic frame_loss_state;
        logic ais_rx;
    } e1rlo_rx_t;

    // Per-framer controls to the datapath
    typedef struct packed {
        logic rx_jitter_fifo_bypass;
        logic frame_search_freeze;
        logic signaling_freeze;
        logic tx_rai;
        logic trunk_condition;
        logic counter_latch;
        logic fer_inc;
    } e1rlo_ctl_t;
endpackage

// *** e1rlo_regs.sv ***
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
module e1rlo_regs
    import e1rlo_pkg::*;
#(
    parameter int SECOND_CYC = E1RLO_SECOND_CYC
)
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic [11:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire e1rlo_rx_t [E1RLO_FRAMERS-1:0] rx_i,
    output e1rlo_ctl_t [E1RLO_FRAMERS-1:0] ctl_o,
    output logic standard_mode_select_o,
    output logic irq_o
);
    localparam int N = E1RLO_FRAMERS;

    // Refuse a second period the counter cannot serve
    if (SECOND_CYC < 2)
    begin : g_second_check
        $error("SECOND_CYC too small");
    end

    typedef struct packed {
        logic [N-1:0][7:0] line;
        logic mode;
        logic [N-1:0] force_rai;
        logic [N-1:0] csel;
        logic wait_req;
        logic [N-1:0] fas_pend;
        logic [N-1:0] stat;
        logic [N-1:0] irq_en;
        logic [N-1:0][15:0] fer;
        logic [31:0] sec_cnt;
        logic [31:0] rdata;
        logic ack;
        logic irq;
        e1rlo_ctl_t [N-1:0] ctl;
    } e1rlo_state_t;

    e1rlo_state_t s_reg;
    e1rlo_state_t s_next;

    logic req;
    logic [2:0] fidx;
    logic line_hit;
    logic sec_tick;
    logic [11:0] fer_off;
    logic [N-1:0] upd_req;
    assign req = (avs_read_i || avs_write_i) && !s_reg.ack;
    assign fidx = avs_address_i[9:7];
    assign line_hit = (avs_address_i[11:10] == 2'b00) && (avs_address_i[6:0] == 7'h00);
    assign sec_tick = (s_reg.sec_cnt == 32'(SECOND_CYC - 1));
    assign fer_off = avs_address_i - E1RLO_FER_ADDR;
    // Host counter update request, one bit per framer
    assign upd_req = (req && avs_write_i && avs_address_i == E1RLO_CTRL_ADDR
        && avs_byteenable_i[2]) ? avs_writedata_i[E1RLO_C_UPD +: N] : '0;

    // Count bit errors in one FAS pattern against the expected FAS word
    function automatic logic [3:0] fas_errs(input logic [6:0] bits);
        logic [3:0] n;
        n = 4'h0;
        for (int b = 0; b < 7; b++)
            n = n + 4'(bits[b] ^ E1RLO_FAS_WORD[b]);
        return n;
    endfunction

    // Next-state logic: register bus, counters, framer controls
    always_comb
    begin
        logic [3:0] ferr;
        logic [3:0] add;
        logic [N-1:0] ev;
        logic [7:0] ln;
        ferr = 4'h0;
        add = 4'h0;
        ev = '0;
        ln = 8'h00;
        s_next = s_reg;
        s_next.ack = req;
        s_next.wait_req = !req;
        if (sec_tick)
            s_next.sec_cnt = 32'h0;
        else
            s_next.sec_cnt = s_reg.sec_cnt + 32'h1;
        // Register writes and reads answered one cycle after request
        if (req && avs_write_i && avs_byteenable_i[0])
        begin
            if (line_hit)
                s_next.line[fidx] = avs_writedata_i[7:0];
            else if (avs_address_i == E1RLO_MODE_ADDR)
                s_next.mode = avs_writedata_i[0];
            else if (avs_address_i == E1RLO_IRQ_EN_ADDR)
                s_next.irq_en = avs_writedata_i[N-1:0];
        end
        if (req && avs_write_i && avs_address_i == E1RLO_CTRL_ADDR)
        begin
            if (avs_byteenable_i[0])
                s_next.force_rai = avs_writedata_i[E1RLO_C_FORCE +: N];
            if (avs_byteenable_i[1])
                s_next.csel = avs_writedata_i[E1RLO_C_CSEL +: N];
        end
        if (req && avs_write_i && avs_address_i == E1RLO_IRQ_CLR_ADDR && avs_byteenable_i[0])
            s_next.stat = s_reg.stat & ~avs_writedata_i[N-1:0];
        s_next.rdata = 32'h0;
        if (req && avs_read_i)
        begin
            if (line_hit)
                s_next.rdata = {24'h0, s_reg.line[fidx]};
            else if (avs_address_i == E1RLO_MODE_ADDR)
                s_next.rdata = {31'h0, s_reg.mode};
            else if (avs_address_i == E1RLO_CTRL_ADDR)
                s_next.rdata = {16'h0, s_reg.csel, s_reg.force_rai};
            else if (avs_address_i == E1RLO_IRQ_STAT_ADDR)
                s_next.rdata = {24'h0, s_reg.stat};
            else if (avs_address_i == E1RLO_IRQ_EN_ADDR)
                s_next.rdata = {24'h0, s_reg.irq_en};
            else if (fer_off[11:5] == 7'h00 && fer_off[1:0] == 2'b00)
                s_next.rdata = {16'h0, s_reg.fer[fer_off[4:2]]};
        end
        for (int f = 0; f < N; f++)
        begin
            ln = s_reg.line[f];
            s_next.ctl[f].rx_jitter_fifo_bypass = ln[E1RLO_B_BYPASS];
            s_next.ctl[f].frame_search_freeze = ln[E1RLO_B_FREEZE];
            s_next.ctl[f].signaling_freeze = ln[E1RLO_B_FREEZE];
            // Remote alarm: forced, or automatic on frame loss or on AIS when selected
            s_next.ctl[f].tx_rai = s_reg.force_rai[f]
                || (ln[E1RLO_B_AUTORAI] && (rx_i[f].frame_loss_state
                || (s_reg.csel[f] && rx_i[f].ais_rx)));
            // Trunk conditioning while any enabled cause persists
            s_next.ctl[f].trunk_condition =
                (ln[E1RLO_B_AUTO_TRUNK_ON_RED] && rx_i[f].red_alarm)
                || (ln[E1RLO_B_AUTO_TRUNK_ON_FRAME_LOSS] && (rx_i[f].frame_loss_state
                || ln[E1RLO_B_FREEZE]));
            s_next.ctl[f].counter_latch = (ln[E1RLO_B_AUTOLATCH] && sec_tick) || upd_req[f];
            // Framing error counting in four modes
            ferr = fas_errs(rx_i[f].fas_bits);
            add = 4'h0;
            if (rx_i[f].fas_valid)
            begin
                if (ln[E1RLO_B_WORD] && ln[E1RLO_B_NFAS])
                    s_next.fas_pend[f] = (ferr != 4'h0);
                else if (ln[E1RLO_B_WORD])
                    add = (ferr != 4'h0) ? 4'h1 : 4'h0;
                else
                    add = ferr;
            end
            if (rx_i[f].nfas_valid && ln[E1RLO_B_NFAS])
            begin
                if (ln[E1RLO_B_WORD])
                begin
                    add = add + 4'((s_reg.fas_pend[f] || !rx_i[f].nfas_bit2) ? 1 : 0);
                    s_next.fas_pend[f] = 1'b0;
                end
                else
                    add = add + 4'(!rx_i[f].nfas_bit2);
            end
            s_next.ctl[f].fer_inc = (add != 4'h0);
            if (s_next.ctl[f].counter_latch)
                s_next.fer[f] = 16'(add);
            else
                s_next.fer[f] = s_reg.fer[f] + 16'(add);
            ev[f] = rx_i[f].red_alarm || rx_i[f].frame_loss_state;
        end
        // Sticky status: events win over clear
        s_next.stat = s_next.stat | ev;
        s_next.irq = |(s_next.stat & s_next.irq_en);
    end

    // State register
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            s_reg <= '0;
            s_reg.mode <= E1RLO_MODE_RESET;
            s_reg.wait_req <= 1'b1;
            for (int f = 0; f < N; f++)
                s_reg.line[f] <= E1RLO_LINE_RESET;
        end
        else
            s_reg <= s_next;
    end

    assign avs_readdata_o = s_reg.rdata;
    assign avs_waitrequest_o = s_reg.wait_req;
    assign ctl_o = s_reg.ctl;
    assign standard_mode_select_o = s_reg.mode;
    assign irq_o = s_reg.irq;

    property p_mode_reset;
        @(posedge clk_sys_i) $rose(reset_n_i) |-> standard_mode_select_o;
    endproperty
    a_mode_reset: assert property (p_mode_reset) else $error("mode not set after reset");

    property p_bypass;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
            ctl_o[0].rx_jitter_fifo_bypass == $past(s_reg.line[0][E1RLO_B_BYPASS]);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass mismatch");

    property p_freeze;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
            $past(s_reg.line[0][E1RLO_B_FREEZE]) |-> ctl_o[0].frame_search_freeze
                && ctl_o[0].signaling_freeze;
    endproperty
    a_freeze: assert property (p_freeze) else $error("freeze missing");

    property p_freeze_oof;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
            $past(s_reg.line[0][E1RLO_B_FREEZE] && s_reg.line[0][E1RLO_B_AUTO_TRUNK_ON_FRAME_LOSS])
                |-> ctl_o[0].trunk_condition;
    endproperty
    a_freeze_oof: assert property (p_freeze_oof) else $error("freeze not as oof");

    property p_rai_force;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
            !$past(s_reg.line[0][E1RLO_B_AUTORAI])
                |-> ctl_o[0].tx_rai == $past(s_reg.force_rai[0]);
    endproperty
    a_rai_force: assert property (p_rai_force) else $error("rai not force only");

    property p_rai_auto;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
            s_reg.line[0][E1RLO_B_AUTORAI] && rx_i[0].frame_loss_state |=> ctl_o[0].tx_rai;
    endproperty
    a_rai_auto: assert property (p_rai_auto) else $error("auto rai missing");

    property p_red;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
            s_reg.line[0][E1RLO_B_AUTO_TRUNK_ON_RED] && rx_i[0].red_alarm |=> ctl_o[0].trunk_condition;
    endproperty
    a_red: assert property (p_red) else $error("red trunk missing");

    property p_trunk_off;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
            !s_reg.line[0][E1RLO_B_AUTO_TRUNK_ON_RED] && !s_reg.line[0][E1RLO_B_AUTO_TRUNK_ON_FRAME_LOSS]
                |=> !ctl_o[0].trunk_condition;
    endproperty
    a_trunk_off: assert property (p_trunk_off) else $error("trunk without enable");

    property p_latch;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
            s_reg.line[0][E1RLO_B_AUTOLATCH] && sec_tick |=> ctl_o[0].counter_latch;
    endproperty
    a_latch: assert property (p_latch) else $error("no second latch");

    // Bus handshake: a waiting request is answered on the next edge
    sequence s_bus_wait;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence s_bus_done;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence
    property p_bus_answer;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
            s_bus_wait |=> s_bus_done;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

    // Mode bit follows an accepted mode write
    sequence s_mode_write;
        req && avs_write_i && avs_byteenable_i[0] && avs_address_i == E1RLO_MODE_ADDR;
    endsequence
    property p_mode_write;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
            s_mode_write |=> standard_mode_select_o == $past(avs_writedata_i[0]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode write lost");

    // Line option register of framer 0 takes an accepted write
    sequence s_line0_write;
        req && avs_write_i && avs_byteenable_i[0] && line_hit && fidx == 3'h0;
    endsequence
    property p_line0_write;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
            s_line0_write |=> s_reg.line[0] == $past(avs_writedata_i[7:0]);
    endproperty
    a_line0_write: assert property (p_line0_write) else $error("line write lost");

    // Any FAS pattern error outside NFAS counting raises an increment
    property p_fas_count;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
            !s_reg.line[0][E1RLO_B_NFAS] && rx_i[0].fas_valid
                && rx_i[0].fas_bits != E1RLO_FAS_WORD |=> ctl_o[0].fer_inc;
    endproperty
    a_fas_count: assert property (p_fas_count) else $error("fas error not counted");

    // Zero second NFAS bit counts in bit mode with NFAS counting
    property p_nfas_count;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
            !s_reg.line[0][E1RLO_B_WORD] && s_reg.line[0][E1RLO_B_NFAS]
                && rx_i[0].nfas_valid && !rx_i[0].nfas_bit2 |=> ctl_o[0].fer_inc;
    endproperty
    a_nfas_count: assert property (p_nfas_count) else $error("nfas error not counted");

    // Combined word mode defers the FAS verdict to the next NFAS frame
    property p_word_defer;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
            s_reg.line[0][E1RLO_B_WORD] && s_reg.line[0][E1RLO_B_NFAS]
                && rx_i[0].fas_valid && !rx_i[0].nfas_valid |=> !ctl_o[0].fer_inc;
    endproperty
    a_word_defer: assert property (p_word_defer) else $error("word error counted early");

    // Selected AIS condition drives automatic remote alarm
    property p_rai_ais;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
            s_reg.line[0][E1RLO_B_AUTORAI] && s_reg.csel[0] && rx_i[0].ais_rx
                |=> ctl_o[0].tx_rai;
    endproperty
    a_rai_ais: assert property (p_rai_ais) else $error("ais rai missing");

    // Frame loss with its enable starts trunk conditioning
    property p_oof_trunk;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
            s_reg.line[0][E1RLO_B_AUTO_TRUNK_ON_FRAME_LOSS] && rx_i[0].frame_loss_state
                |=> ctl_o[0].trunk_condition;
    endproperty
    a_oof_trunk: assert property (p_oof_trunk) else $error("oof trunk missing");

    // Red-only conditioning ends once red alarm clears
    property p_red_end;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
            !s_reg.line[0][E1RLO_B_AUTO_TRUNK_ON_FRAME_LOSS] && !rx_i[0].red_alarm
                |=> !ctl_o[0].trunk_condition;
    endproperty
    a_red_end: assert property (p_red_end) else $error("trunk after red cleared");

    // Host update request latches on the next edge
    property p_host_latch;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
            upd_req[0] |=> ctl_o[0].counter_latch;
    endproperty
    a_host_latch: assert property (p_host_latch) else $error("host latch missing");

    // No latch without a second tick or a host request
    property p_latch_quiet;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
            !sec_tick && !upd_req[0] |=> !ctl_o[0].counter_latch;
    endproperty
    a_latch_quiet: assert property (p_latch_quiet) else $error("latch without cause");
endmodule

// *** e1rlo_rx_model.sv ***
`timescale 1ns/1ps
// Receive datapath stand-in: framing events and alarm levels
module e1rlo_rx_model
    import e1rlo_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic [2:0] sel_i,
    input wire logic fas_go_i,
    input wire logic nfas_go_i,
    input wire logic [6:0] bits_i,
    input wire logic bit2_i,
    input wire logic [7:0] red_i,
    input wire logic [7:0] loss_i,
    input wire logic [7:0] ais_i,
    output e1rlo_rx_t [E1RLO_FRAMERS-1:0] rx_o
);
    // One-cycle frame strobes; data toggles while unqualified
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rx_o <= '0;
        else
            for (int n = 0; n < E1RLO_FRAMERS; n++)
            begin
                rx_o[n].fas_valid <= fas_go_i && (sel_i == n[2:0]);
                rx_o[n].fas_bits <= fas_go_i ? bits_i : ~rx_o[n].fas_bits;
                rx_o[n].nfas_valid <= nfas_go_i && (sel_i == n[2:0]);
                rx_o[n].nfas_bit2 <= nfas_go_i ? bit2_i : ~rx_o[n].nfas_bit2;
                rx_o[n].red_alarm <= red_i[n];
                rx_o[n].frame_loss_state <= loss_i[n];
                rx_o[n].ais_rx <= ais_i[n];
            end
    end
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
    import e1rlo_pkg::*;
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [11:0] adr = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = '0;
    logic [3:0] be = 4'hf;
    logic [31:0] rdat;
    logic wreq;
    e1rlo_rx_t [E1RLO_FRAMERS-1:0] rx;
    e1rlo_ctl_t [E1RLO_FRAMERS-1:0] ctl;
    logic mode;
    logic irq;
    logic fgo = 1'b0;
    logic ngo = 1'b0;
    logic [6:0] bits = '0;
    logic bit2 = 1'b0;
    logic [7:0] red = '0;
    logic [7:0] loss = '0;
    logic [7:0] ais = '0;
    int n_errors = 0;
    int samples_checked = 0;
    int n_latch = 0;
    int n_inc = 0;
    logic [31:0] rv;
    always #4 clk_sys_i = ~clk_sys_i;
    // Counts latch and framing error pulses of framer 0
    always @(negedge clk_sys_i)
    begin
        if (ctl[0].counter_latch === 1'b1)
            n_latch++;
        if (ctl[0].fer_inc === 1'b1)
            n_inc++;
    end
    e1rlo_regs #(.SECOND_CYC(50)) e1rlo_regs_i (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
        .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .rx_i(rx),
        .ctl_o(ctl), .standard_mode_select_o(mode), .irq_o(irq));
    e1rlo_rx_model e1rlo_rx_model_i (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .sel_i(3'h0), .fas_go_i(fgo), .nfas_go_i(ngo), .bits_i(bits), .bit2_i(bit2),
        .red_i(red), .loss_i(loss), .ais_i(ais), .rx_o(rx));
    task automatic summarize();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
        samples_checked++;
        if (s !== e)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic chkb(string nm, logic s, logic e);
        chk(nm, {31'h0, s}, {31'h0, e});
    endtask
    // One bus cycle, held until waitrequest is sampled low at a rising edge
    task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
        int i;
        i = 0;
        @(posedge clk_sys_i);
        adr <= a;
        wdat <= d;
        rd <= !w;
        wr <= w;
        @(posedge clk_sys_i);
        while (wreq !== 1'b0 && i < 20)
        begin
            @(posedge clk_sys_i);
            i++;
        end
        if (i == 20)
        begin
            n_errors++;
            summarize();
        end
        rv = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wt(int k);
        repeat (k) @(negedge clk_sys_i);
    endtask
    task automatic t_regs();
        bus(0, E1RLO_MODE_ADDR, 0);
        chk("mode reg", rv, 32'h1);
        chkb("mode pin", mode, 1'b1);
        for (int n = 0; n < 8; n++)
        begin
            bus(0, 12'(n * 128), 0);
            chk("line reset", rv, 32'h0);
            bus(1, 12'(n * 128), 32'hc0 | n);
            bus(0, 12'(n * 128), 0);
            chk("line rw", rv, 32'hc0 | n);
            bus(1, 12'(n * 128), 0);
        end
        bus(0, 12'h7fc, 0);
        chk("unmapped", rv, 32'h0);
        bus(1, E1RLO_MODE_ADDR, 0);
        wt(2);
        chkb("mode e1", mode, 1'b0);
        bus(1, E1RLO_MODE_ADDR, 1);
        $display("test regs done");
    endtask
    task automatic t_path();
        bus(1, 12'h100, 32'hc0);
        wt(2);
        chkb("bypass", ctl[2].rx_jitter_fifo_bypass, 1'b1);
        chkb("bypass other", ctl[1].rx_jitter_fifo_bypass, 1'b0);
        chkb("search", ctl[2].frame_search_freeze, 1'b1);
        chkb("sig", ctl[2].signaling_freeze, 1'b1);
        bus(1, 12'h100, 32'h42);
        wt(2);
        chkb("freeze trunk", ctl[2].trunk_condition, 1'b1);
        bus(1, 12'h100, 0);
        $display("test path done");
    endtask
    task automatic fer(logic [7:0] o, logic [6:0] b, logic b2, logic [31:0] add);
        logic [31:0] r0;
        int k;
        k = n_inc;
        bus(1, 12'h000, {24'h0, o});
        bus(0, 12'h418, 0);
        r0 = rv;
        @(posedge clk_sys_i);
        fgo <= 1'b1;
        bits <= b;
        @(posedge clk_sys_i);
        fgo <= 1'b0;
        ngo <= 1'b1;
        bit2 <= b2;
        @(posedge clk_sys_i);
        ngo <= 1'b0;
        wt(3);
        bus(0, 12'h418, 0);
        chk("fer add", rv - r0, add);
        chkb("fer pulse", n_inc != k, add != 0);
    endtask
    task automatic t_fer();
        fer(8'h00, 7'h1c, 1'b0, 3);
        fer(8'h20, 7'h1c, 1'b1, 1);
        fer(8'h10, 7'h18, 1'b0, 3);
        fer(8'h30, 7'h18, 1'b0, 1);
        fer(8'h30, 7'h1b, 1'b0, 1);
        fer(8'h30, 7'h1b, 1'b1, 0);
        bus(1, 12'h000, 0);
        $display("test fer done");
    endtask
    task automatic t_alarm();
        bus(1, E1RLO_CTRL_ADDR, 1);
        wt(2);
        chkb("rai force", ctl[0].tx_rai, 1'b1);
        bus(1, E1RLO_CTRL_ADDR, 0);
        loss <= 8'h01;
        wt(3);
        chkb("rai off", ctl[0].tx_rai, 1'b0);
        bus(1, 12'h000, 32'h08);
        wt(2);
        chkb("rai loss", ctl[0].tx_rai, 1'b1);
        @(posedge clk_sys_i);
        loss <= 8'h00;
        ais <= 8'h01;
        wt(3);
        chkb("rai ais sel0", ctl[0].tx_rai, 1'b0);
        bus(1, E1RLO_CTRL_ADDR, 32'h100);
        wt(2);
        chkb("rai ais sel1", ctl[0].tx_rai, 1'b1);
        ais <= 8'h00;
        bus(1, 12'h000, 32'h04);
        red <= 8'h01;
        wt(3);
        chkb("trunk red", ctl[0].trunk_condition, 1'b1);
        red <= 8'h00;
        wt(3);
        chkb("trunk end", ctl[0].trunk_condition, 1'b0);
        bus(1, 12'h000, 32'h02);
        loss <= 8'h01;
        wt(3);
        chkb("trunk oof", ctl[0].trunk_condition, 1'b1);
        bus(1, 12'h000, 0);
        wt(2);
        chkb("trunk off", ctl[0].trunk_condition, 1'b0);
        loss <= 8'h00;
        $display("test alarm done");
    endtask
    task automatic t_irq();
        bus(1, E1RLO_IRQ_CLR_ADDR, 32'hff);
        bus(1, E1RLO_IRQ_EN_ADDR, 1);
        red <= 8'h01;
        wt(2);
        red <= 8'h00;
        wt(3);
        chkb("irq set", irq, 1'b1);
        bus(0, E1RLO_IRQ_STAT_ADDR, 0);
        chk("status", rv, 32'h1);
        bus(1, E1RLO_IRQ_EN_ADDR, 0);
        wt(2);
        chkb("irq mask", irq, 1'b0);
        bus(1, E1RLO_IRQ_CLR_ADDR, 1);
        bus(0, E1RLO_IRQ_STAT_ADDR, 0);
        chk("status clr", rv, 32'h0);
        $display("test irq done");
    endtask
    task automatic t_latch();
        int k;
        k = n_latch;
        wt(100);
        chk("no auto", n_latch - k, 0);
        bus(1, E1RLO_CTRL_ADDR, 32'h10000);
        wt(2);
        chk("host latch", n_latch - k, 1);
        bus(1, 12'h000, 32'h01);
        k = n_latch;
        wt(100);
        chk("auto latch", n_latch - k, 2);
        $display("test latch done");
    endtask
    initial
    begin
        repeat (12) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        t_regs();
        t_path();
        t_fer();
        t_alarm();
        t_irq();
        t_latch();
        summarize();
    end
endmodule
